// file: osc_ctrl_pkg.sv
// Package: register map, fields and constants for the oscillator control
package osc_ctrl_pkg;
    // Special-function register addresses
    localparam logic [7:0] ADDR_OSC_CONTROL = 8'ha1;
    localparam logic [7:0] ADDR_OSC_TRIM    = 8'ha2;
    // Control and trim register fields
    localparam int EN_HI      = 7;
    localparam int EN_LO      = 6;
    localparam int SUSP_BIT   = 5;
    localparam int RDY_BIT    = 4;
    localparam int RSVD_BIT   = 3;
    localparam int DIV_HI     = 2;
    localparam int TRIM_HI    = 6;
    // Enable field codes
    localparam logic [1:0] EN_OFF = 2'h0;
    localparam logic [1:0] EN_ON  = 2'h3;
    // Reset values and top divider code
    localparam logic [1:0] EN_RESET  = 2'h3;
    localparam logic [2:0] DIV_RESET = 3'h0;  // Divide by 128
    localparam logic [2:0] DIV_MAX   = 3'h7;  // Divide by 1
    // Clock source select code for the internal oscillator
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    // Oscillator power states
    typedef enum logic [1:0] {OSC_OFF, OSC_RUN, OSC_SUSPENDED} osc_state_t;
endpackage

// file: system_clock_divider.sv
// Power-of-two divider producing a glitch-free one-cycle clock enable
`timescale 1ns/1ps
module system_clock_divider
    import osc_ctrl_pkg::*;
#(
    parameter int SEL_W = 3
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             run_i,
    input  wire logic [SEL_W-1:0] select_i,
    output logic                  tick_o
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    logic [CNT_W-1:0] count;
    logic [SEL_W-1:0] active_sel;
    logic [CNT_W-1:0] limit;
    logic             wrap;

    // Divisor of 2**(max - code), minus one, as terminal count
    assign limit = CNT_W'((1 << (DIV_MAX - active_sel)) - 1);
    assign wrap  = (count == limit);
    assign tick_o = run_i & wrap;

    // New select only taken at a period boundary, so no runt period
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count      <= '0;
            active_sel <= DIV_RESET;
        end else if (run_i) begin
            count <= wrap ? '0 : count + 1'b1;
            if (wrap)
                active_sel <= select_i;
        end
    end

    // Divide-by-1 kept only while the select stays at divide-by-1
    tick_period_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) tick_o && active_sel == DIV_MAX && select_i == DIV_MAX
        |-> ##1 (tick_o || !run_i)) else $error("divide-by-1 stalled");
endmodule // system_clock_divider

// file: internal_osc_control.sv
// Internal oscillator control: enable, suspend, ready flag, divider, trim
`timescale 1ns/1ps
// Function
// - Enable field 00 stops oscillator; 11 runs it except while suspended.
// - Writing suspend bit one suspends; any wake event restarts oscillator.
// - Read-only ready flag is one only when running at programmed frequency.
// - Reserved control bit reads zero; software writes zero.
// - Divider code 000 divides by 128, each step halves, 111 divides by 1.
// - Trim 0000000 slowest, 1111111 fastest, intermediate codes between.
// - Trim loads factory value for nominal 24 MHz after reset.
// - Trim register top bit reads zero and ignores writes.
// - Divider applies only when clock source select picks internal oscillator.
// - Wake on any port match or comparator 0 enabled with low output.
// - After reset oscillator enabled and divider set to divide by 128.
module internal_osc_control
    import osc_ctrl_pkg::*;
#(
    parameter logic [6:0] TRIM_FACTORY = 7'h40,  // Per-part calibration
    parameter int         SETTLE_CYCLES = 16,    // Ready delay after start
    parameter int         PORTS         = 4
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [7:0]       sfr_addr_i,
    input  wire logic [7:0]       sfr_wdata_i,
    input  wire logic             sfr_wr_i,
    input  wire logic             sfr_rd_i,
    output logic      [7:0]       sfr_rdata_o,
    input  wire logic [1:0]       clock_source_select_i,
    input  wire logic [PORTS-1:0] port_match_i,
    input  wire logic             cmp0_enable_i,
    input  wire logic             cmp0_out_i,
    output logic                  osc_running_o,
    output logic      [6:0]       osc_period_trim_o,
    output logic                  system_clock_tick_o,
    output logic                  system_clock_from_osc_o
);
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

    osc_state_t            state;
    osc_state_t            next_state;
    logic [1:0]            osc_enable_field;
    logic                  suspend_req;
    logic [2:0]            system_clock_divider_select;
    logic [6:0]            coarse_trim;
    logic [SETTLE_W-1:0]   settle_count;
    logic                  freq_ready_flag;
    logic                  wr_ctrl;
    logic                  wr_trim;
    logic                  wake_event;
    logic                  div_tick;
    logic [7:0]            ctrl_view;

    // Register decode
    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == ADDR_OSC_CONTROL);
    assign wr_trim = sfr_wr_i && (sfr_addr_i == ADDR_OSC_TRIM);

    // Any port match or comparator 0 enabled and low wakes the oscillator
    assign wake_event = (|port_match_i)
                     || (cmp0_enable_i && !cmp0_out_i);

    // Control register fields
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_enable_field      <= EN_RESET;
            system_clock_divider_select <= DIV_RESET;
            suspend_req           <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                osc_enable_field      <= sfr_wdata_i[EN_HI:EN_LO];
                system_clock_divider_select <= sfr_wdata_i[DIV_HI:0];
            end
            // Wake wins over a same-cycle suspend write
            if (wake_event)
                suspend_req <= 1'b0;
            else if (wr_ctrl)
                suspend_req <= sfr_wdata_i[SUSP_BIT];
        end
    end

    // Coarse trim, factory value at reset, top bit dropped
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            coarse_trim <= TRIM_FACTORY;
        else if (wr_trim)
            coarse_trim <= sfr_wdata_i[TRIM_HI:0];
    end
    assign osc_period_trim_o = coarse_trim;

    // Oscillator power state
    always_comb begin
        next_state = state;
        case (state)
            OSC_OFF:
                if (osc_enable_field == EN_ON && !suspend_req)
                    next_state = OSC_RUN;
            OSC_RUN:
                if (osc_enable_field != EN_ON)
                    next_state = OSC_OFF;
                else if (suspend_req)
                    next_state = OSC_SUSPENDED;
            OSC_SUSPENDED:
                if (osc_enable_field != EN_ON)
                    next_state = OSC_OFF;
                else if (!suspend_req)
                    next_state = OSC_RUN;
            default:
                next_state = OSC_OFF;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            state <= OSC_RUN;
        else
            state <= next_state;
    end
    assign osc_running_o = (state == OSC_RUN);

    // Settle counter drives the ready flag after each restart
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            settle_count <= '0;
        else if (state != OSC_RUN)
            settle_count <= '0;
        else if (settle_count != SETTLE_W'(SETTLE_CYCLES))
            settle_count <= settle_count + 1'b1;
    end
    assign freq_ready_flag = osc_running_o
        && (settle_count == SETTLE_W'(SETTLE_CYCLES));

    // Count held mid-period on stop; divider only runs with oscillator
    system_clock_divider #(
        .SEL_W (3)
    ) u_div (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (osc_running_o),
        .select_i  (system_clock_divider_select),
        .tick_o    (div_tick)
    );

    // Divided clock only reaches the system clock when selected
    assign system_clock_from_osc_o = (clock_source_select_i == SRC_INTERNAL);
    assign system_clock_tick_o = div_tick && system_clock_from_osc_o;

    // Read data: reserved bit zero, unused trim bit zero
    assign ctrl_view = {osc_enable_field, suspend_req, freq_ready_flag,
                        1'b0, system_clock_divider_select};
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            sfr_rdata_o <= 8'h00;
        else if (sfr_rd_i)
            sfr_rdata_o <= (sfr_addr_i == ADDR_OSC_CONTROL) ? ctrl_view
                         : (sfr_addr_i == ADDR_OSC_TRIM) ? {1'b0, coarse_trim}
                         : 8'h00;
    end

    // Assertions
    en_off_stops_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) osc_enable_field == EN_OFF |-> ##1 !osc_running_o)
        else $error("oscillator running while disabled");
    suspend_stops_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) wr_ctrl && sfr_wdata_i[SUSP_BIT] && !wake_event
        |-> ##2 !osc_running_o) else $error("suspend did not stop");
    // A same-cycle control write may legally turn the oscillator off
    wake_resumes_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) state == OSC_SUSPENDED && wake_event && !wr_ctrl
        && osc_enable_field == EN_ON |-> ##2 osc_running_o)
        else $error("wake did not restart oscillator");

    // Ready seen through the read path while stopped
    ready_flag_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) $past(sfr_rd_i) && $past(sfr_addr_i) == ADDR_OSC_CONTROL
        && !$past(osc_running_o) |-> !sfr_rdata_o[RDY_BIT])
        else $error("ready flag set while stopped");
    // Ready never claimed in the cycle the oscillator restarts
    ready_restart_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) $rose(osc_running_o) |-> !freq_ready_flag)
        else $error("ready flag set at restart");

    // Reserved enable codes behave as off
    reserved_off_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) osc_enable_field != EN_ON |-> ##1 !osc_running_o)
        else $error("oscillator running with reserved enable");

    // Read-back of the fixed zero bits
    rsvd_read_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) $past(sfr_rd_i) && $past(sfr_addr_i) == ADDR_OSC_CONTROL
        |-> !sfr_rdata_o[RSVD_BIT]) else $error("reserved bit not zero");
    trim_top_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) $past(sfr_rd_i) && $past(sfr_addr_i) == ADDR_OSC_TRIM
        |-> !sfr_rdata_o[TRIM_HI+1]) else $error("trim top bit not zero");

    // Register writes land on the next edge; no tick with external source or while stopped
    trim_write_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) wr_trim |=> osc_period_trim_o
        == $past(sfr_wdata_i[TRIM_HI:0]))
        else $error("trim write not applied");
    div_write_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) wr_ctrl |=> system_clock_divider_select
        == $past(sfr_wdata_i[DIV_HI:0])) else $error("divider not written");
    src_gate_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) clock_source_select_i != SRC_INTERNAL |-> !system_clock_tick_o)
        else $error("tick with external source");
    stop_no_tick_a: assert property (@(posedge ref_clk_i) disable iff
        (!rst_n_i) !osc_running_o |-> !system_clock_tick_o)
        else $error("tick while oscillator stopped");

    cov_suspend_wake_c: cover property (@(posedge ref_clk_i)
        state == OSC_SUSPENDED ##1 state == OSC_RUN);
    cov_ready_c: cover property (@(posedge ref_clk_i) $rose(freq_ready_flag));
    cov_div1_c: cover property (@(posedge ref_clk_i)
        system_clock_divider_select == DIV_MAX && system_clock_tick_o ##1 system_clock_tick_o);
    cov_off_c: cover property (@(posedge ref_clk_i) state == OSC_OFF);
    cov_reserved_c: cover property (@(posedge ref_clk_i)
        osc_enable_field != EN_ON && osc_enable_field != EN_OFF);
endmodule // internal_osc_control

// file: tb_internal_osc_control.sv
// Self-checking testbench for the internal oscillator control block
`timescale 1ns/1ps
module tb_internal_osc_control
    import osc_ctrl_pkg::*;
;
    localparam logic [6:0] FACT = 7'h2a;  // Arbitrary factory trim value
    logic       ref_clk_i             = 1'b0;
    logic       rst_n_i               = 1'b0;
    logic       sfr_wr_i              = 1'b0;
    logic       sfr_rd_i              = 1'b0;
    logic       cmp0_enable_i         = 1'b0;
    logic       cmp0_out_i            = 1'b1;
    logic [7:0] sfr_addr_i            = 8'h00;
    logic [7:0] sfr_wdata_i           = 8'h00;
    logic [1:0] clock_source_select_i = 2'h0;
    logic [3:0] port_match_i          = 4'h0;
    logic [7:0] v;
    wire  [7:0] sfr_rdata_o;
    wire  [6:0] osc_period_trim_o;
    wire        osc_running_o;
    wire        system_clock_tick_o;
    wire        system_clock_from_osc_o;
    int         n_fail     = 0;
    int         num_checks = 0;
    int         p;

    internal_osc_control #(
        .TRIM_FACTORY  (FACT),
        .SETTLE_CYCLES (2)
    ) internal_osc_control_i (
        .ref_clk_i             (ref_clk_i),
        .rst_n_i               (rst_n_i),
        .sfr_addr_i            (sfr_addr_i),
        .sfr_wdata_i           (sfr_wdata_i),
        .sfr_wr_i              (sfr_wr_i),
        .sfr_rd_i              (sfr_rd_i),
        .sfr_rdata_o           (sfr_rdata_o),
        .clock_source_select_i (clock_source_select_i),
        .port_match_i          (port_match_i),
        .cmp0_enable_i         (cmp0_enable_i),
        .cmp0_out_i            (cmp0_out_i),
        .osc_running_o         (osc_running_o),
        .osc_period_trim_o     (osc_period_trim_o),
        .system_clock_tick_o         (system_clock_tick_o),
        .system_clock_from_osc_o     (system_clock_from_osc_o)
    );

    // Free-running 100 MHz clock
    initial forever #5 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [7:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    // Advance whole cycles, landing just after the edge
    task automatic step(input int n);
        repeat (n) begin @(posedge ref_clk_i); #1; end
    endtask
    task automatic wr(input logic [7:0] a, d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        step(1);
        sfr_wr_i = 1'b0;
    endtask
    // Read strobe for one edge, data taken once it stands, one idle cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        step(1);
        sfr_rd_i = 1'b0;
        d = sfr_rdata_o;
        step(1);
    endtask
    // Cycles between two ticks of the divided clock, skipping one period
    task automatic period(output int q);
        repeat (2) begin
            int n;
            n = 0;
            while (system_clock_tick_o !== 1'b1 && n < 300) begin step(1); n++; end
            q = 0;
            do begin step(1); q++; end while (system_clock_tick_o !== 1'b1 && q < 300);
        end
    endtask
    task automatic t_reset();
        rst_n_i = 1'b0;
        step(3);
        rst_n_i = 1'b1;
        step(5);
        rd(ADDR_OSC_CONTROL, v);
        chk(v, 8'hd0, "ctrl reset");
        rd(ADDR_OSC_TRIM, v);
        chk(v, {1'b0, FACT}, "trim reset");
        chk({1'b0, osc_period_trim_o}, {1'b0, FACT}, "trim out");
        chk({7'h0, osc_running_o}, 8'h01, "running");
        period(p);
        chk(p[7:0], 8'h80, "reset period");
        $display("test reset done");
    endtask
    task automatic t_div();
        for (int c = 0; c < 8; c++) begin
            // Ready bit written as one is ignored, reserved bit kept zero
            wr(ADDR_OSC_CONTROL, {5'b11010, c[2:0]});
            period(p);
            chk(p[7:0], 8'(1 << (7 - c)), "period");
            rd(ADDR_OSC_CONTROL, v);
            chk(v, {5'b11010, c[2:0]}, "ctrl");
        end
        $display("test divider done");
    endtask
    task automatic t_trim();
        wr(ADDR_OSC_TRIM, 8'hff);
        rd(ADDR_OSC_TRIM, v);
        chk(v, 8'h7f, "trim ff");
        chk({1'b0, osc_period_trim_o}, 8'h7f, "trim out ff");
        wr(ADDR_OSC_TRIM, 8'h00);
        rd(ADDR_OSC_TRIM, v);
        chk(v, 8'h00, "trim 00");
        chk({1'b0, osc_period_trim_o}, 8'h00, "trim out 00");
        $display("test trim done");
    endtask
    task automatic t_susp();
        for (int s = 0; s < 5; s++) begin
            cmp0_enable_i = 1'b1;  // Enabled but high output must not wake
            wr(ADDR_OSC_CONTROL, 8'he7);
            step(2);
            chk({7'h0, osc_running_o}, 8'h00, "suspended");
            chk({7'h0, system_clock_tick_o}, 8'h00, "tick stopped");
            rd(ADDR_OSC_CONTROL, v);
            chk(v, 8'he7, "ctrl susp");
            if (s < 4)
                port_match_i[s] = 1'b1;
            else
                cmp0_out_i = 1'b0;
            step(1);
            port_match_i = 4'h0;
            cmp0_out_i = 1'b1;
            cmp0_enable_i = 1'b0;
            step(5);
            // Running judged from the state output, not the ready flag
            chk({7'h0, osc_running_o}, 8'h01, "woken");
            rd(ADDR_OSC_CONTROL, v);
            chk(v, 8'hd7, "ctrl woken");
        end
        $display("test suspend done");
    endtask
    task automatic t_en();
        for (int e = 0; e < 3; e++) begin
            wr(ADDR_OSC_CONTROL, {e[1:0], 6'h07});
            step(3);
            chk({7'h0, osc_running_o}, 8'h00, "disabled");
            rd(ADDR_OSC_CONTROL, v);
            chk(v, {e[1:0], 6'h07}, "ctrl off");
        end
        wr(ADDR_OSC_CONTROL, 8'hc7);
        step(5);
        chk({7'h0, osc_running_o}, 8'h01, "enabled");
        rd(ADDR_OSC_CONTROL, v);
        chk(v, 8'hd7, "ctrl on");
        $display("test enable done");
    endtask
    task automatic t_misc();
        // Divider at divide-by-1, so a tick stands every cycle when routed
        clock_source_select_i = 2'h1;
        step(1);
        chk({7'h0, system_clock_from_osc_o}, 8'h00, "src ext");
        chk({7'h0, system_clock_tick_o}, 8'h00, "tick ext");
        clock_source_select_i = SRC_INTERNAL;
        step(1);
        chk({7'h0, system_clock_from_osc_o}, 8'h01, "src int");
        chk({7'h0, system_clock_tick_o}, 8'h01, "tick int");
        wr(8'ha3, 8'hff);
        rd(8'ha3, v);
        chk(v, 8'h00, "unmapped");
        rd(ADDR_OSC_CONTROL, v);
        chk(v, 8'hd7, "ctrl kept");
        $display("test misc done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Main sequence, a second reset as the last test included
    initial begin
        t_reset();
        t_div();
        t_trim();
        t_susp();
        t_en();
        t_misc();
        t_reset();
        results();
    end
    // Watchdog well beyond the expected run
    initial begin
        #500000;
        n_fail++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        results();
    end
endmodule // tb_internal_osc_control
